// ===== bench/bbsp_host_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "bbsp_defines.svh"
module bbsp_host_sva (
  input wire logic                    sys_clk_in,
  input wire logic                    rst_in,
  input wire logic [`BBSP_ADDR_W-1:0] address_pins_out,
  input wire logic                    chip_en_n_out,
  input wire logic                    out_en_n_out,
  input wire logic                    wr_en_n_out,
  input wire logic [`BBSP_DATA_W-1:0] data_pins_out,
  input wire logic                    data_pins_oe_out
);
  logic [7:0] dat_prev_r;  // drive value one cycle back
  logic [3:0] dat_age_r;   // cycles the drive value has held
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // age of the host's write data on the pins
  always_ff @(posedge sys_clk_in) begin
    dat_prev_r <= data_pins_out;
    if (rst_in || !data_pins_oe_out || data_pins_out != dat_prev_r) dat_age_r <= 4'h0;
    else if (dat_age_r != 4'hF) dat_age_r <= dat_age_r + 4'h1;
  end
  sequence s_wr_start;
    $fell(wr_en_n_out);
  endsequence
  sequence s_wr_low;
    !wr_en_n_out [*4];
  endsequence
  chk_strobe_width: assert property (s_wr_start |-> s_wr_low)
    else $error("write strobe too short");
  chk_cycle_gap: assert property ($fell(chip_en_n_out) |=> (!$fell(chip_en_n_out)) [*4])
    else $error("memory cycles too close");
  chk_addr_hold: assert property (!$past(wr_en_n_out) |-> $stable(address_pins_out))
    else $error("address moved in or just after write");
  chk_data_setup: assert property (
    $rose(wr_en_n_out) |-> dat_age_r >= 4'h3 && data_pins_oe_out && data_pins_out == dat_prev_r)
    else $error("write data setup or hold short");
  chk_oe_quiet: assert property ((!wr_en_n_out || data_pins_oe_out) |-> out_en_n_out)
    else $error("output enable low while writing");
endmodule
bind bbsp_host bbsp_host_sva bbsp_host_sva_i (
  .sys_clk_in(sys_clk_in),
  .rst_in(rst_in),
  .address_pins_out(address_pins_out),
  .chip_en_n_out(chip_en_n_out),
  .out_en_n_out(out_en_n_out),
  .wr_en_n_out(wr_en_n_out),
  .data_pins_out(data_pins_out),
  .data_pins_oe_out(data_pins_oe_out)
);
`default_nettype wire

// ===== bench/bbsp_host_test.sv
`timescale 1ns/1ns
`default_nettype none
module bbsp_host_test;
  import bbsp_pkg::*;
  localparam int REC_NS = 2000;     // shortened recovery delay
  logic        sys_clk   = 1'b0;
  logic        rst       = 1'b1;
  logic        req_valid = 1'b0;
  bbsp_cmd_t   req_cmd   = BBSP_CMD_READ;
  logic [14:0] req_addr  = '0;
  logic [7:0]  req_wdata = '0;
  logic        supply_ok = 1'b0;    // supply in tolerance
  logic        batt_weak = 1'b1;    // cell low at power-up
  logic [7:0]  flt       = 8'h00;   // floating bus pattern
  logic        ready, rsp_valid, blow, ce_n, oe_n, we_n, h_oe, d_oe, got_b;
  logic [7:0]  rdata, h_q, d_q, wire_q, got_d;
  logic [14:0] addr_p;
  logic [7:0]  em [int];            // bench model of the array
  int          q [$];               // addresses to read back
  int          a, err_total = 0, checks_done = 0;
  initial forever #10 sys_clk = ~sys_clk;
  // wire level: host, else device, else a moving pattern
  always @(posedge sys_clk) flt <= flt + 8'h3B;
  assign wire_q = h_oe ? h_q : (d_oe ? d_q : flt);
  bbsp_host bbsp_host_i (.sys_clk_in(sys_clk), .rst_in(rst), .req_valid_in(req_valid),
    .req_cmd_in(req_cmd), .req_addr_in(req_addr), .req_wdata_in(req_wdata),
    .req_ready_out(ready), .rsp_valid_out(rsp_valid), .rsp_rdata_out(rdata),
    .rsp_batt_low_out(blow), .address_pins_out(addr_p), .chip_en_n_out(ce_n),
    .out_en_n_out(oe_n), .wr_en_n_out(we_n), .data_pins_in(wire_q),
    .data_pins_out(h_q), .data_pins_oe_out(h_oe));
  bbsp_sram_model #(.REC_NS(REC_NS)) bbsp_sram_model_i (.address_pins_in(addr_p),
    .chip_en_n_in(ce_n), .out_en_n_in(oe_n), .wr_en_n_in(we_n), .data_pins_in(wire_q),
    .supply_ok_in(supply_ok), .batt_weak_in(batt_weak), .data_pins_out(d_q),
    .data_pins_oe_out(d_oe));
  function automatic logic [7:0] exp_of(input int a);
    return em.exists(a) ? em[a] : (8'(a) ^ 8'hA5);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  // one request, held for one cycle, then wait for the answer pulse
  task automatic op(input bbsp_cmd_t c, input int a, input logic [7:0] w);
    int n;
    @(negedge sys_clk);
    chk({7'h0, ready}, 8'h01, "not ready before request");
    req_valid = 1'b1;
    req_cmd   = c;
    req_addr  = 15'(a);
    req_wdata = w;
    @(negedge sys_clk);
    req_valid = 1'b0;
    chk({7'h0, ready}, 8'h00, "still ready after take");
    for (n = 0; n < 200 && rsp_valid !== 1'b1; n++) @(negedge sys_clk);
    if (n == 200) chk(8'h00, 8'h01, "no answer");
    got_d = rdata;
    got_b = blow;
  endtask
  task automatic rd(input int a);
    op(BBSP_CMD_READ, a, 8'h00);
    chk(got_d, exp_of(a), "read byte");
  endtask
  task automatic wr(input int a, input logic [7:0] d, input logic lands);
    op(BBSP_CMD_WRITE, a, d);
    if (lands) em[a] = d;
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // watchdog: some thirty operations plus two recovery waits
  initial begin
    #200000;
    chk(8'h00, 8'h01, "timeout");
    end_of_test();
  end
  initial begin
    void'($urandom(32'h29C3));
    #1 supply_ok = 1'b1;
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    #(REC_NS);
    // first check meets the weak cell, the second finds it cleared
    for (int i = 0; i < 2; i++) begin
      a = $urandom % 32768;
      op(BBSP_CMD_CHECK, a, 8'h00);
      chk(got_d, exp_of(a), "check byte");
      chk({7'h0, got_b}, (i == 0) ? 8'h01 : 8'h00, "battery flag");
      rd(a);
    end
    $display("test battery check done");
    // back-to-back writes at both ends and inside, read back in reverse
    q = '{0, 32767};
    repeat (6) q.push_back($urandom % 32768);
    foreach (q[i]) wr(q[i], 8'($urandom), 1'b1);
    while (q.size() > 0) rd(q.pop_back());
    op(bbsp_cmd_t'(2'h3), 5, 8'h00);
    chk(got_d, exp_of(5), "spare code read");
    $display("test write read done");
    // writes during a supply fault and during recovery are lost
    a = $urandom % 32767 + 1;
    @(negedge sys_clk) supply_ok = 1'b0;
    wr(a, ~exp_of(a), 1'b0);
    batt_weak = 1'b0;
    supply_ok = 1'b1;
    wr(a, 8'h5A, 1'b0);
    #(REC_NS);
    rd(a);
    rd(0);
    wr(a, 8'h3C, 1'b1);
    rd(a);
    $display("test power fail done");
    end_of_test();
  end
endmodule
`default_nettype wire

// ===== bench/bbsp_sram_model.sv
`timescale 1ns/1ns
`default_nettype none
module bbsp_sram_model #(
  parameter int REC_NS = 2000  // recovery delay, shortened
) (
  input  wire logic [14:0] address_pins_in,
  input  wire logic        chip_en_n_in,
  input  wire logic        out_en_n_in,
  input  wire logic        wr_en_n_in,
  input  wire logic [7:0]  data_pins_in,
  input  wire logic        supply_ok_in,  // supply in tolerance
  input  wire logic        batt_weak_in,  // cell below 2.5 V
  output logic      [7:0]  data_pins_out,
  output logic             data_pins_oe_out
);
  logic [7:0] mem [0:32767];     // storage array
  logic       pwr_ok = 1'b0;     // supply good and recovered
  logic       batt_low_flag = 1'b0;
  logic [7:0] q_r = 8'h00;       // byte shown on the pins
  time        t_chg = 0;         // last address or enable change
  initial for (int i = 0; i < 32768; i++) mem[i] = 8'(i) ^ 8'hA5;
  // off battery on return, test cell, then recover
  always @(supply_ok_in) begin
    pwr_ok = 1'b0;
    if (supply_ok_in) batt_low_flag = batt_weak_in;
    if (supply_ok_in) #(REC_NS) pwr_ok = supply_ok_in;
  end
  // old byte held 10 ns, then indeterminate until access completes
  always @(address_pins_in or chip_en_n_in or out_en_n_in) t_chg = $time;
  always #5 begin
    if ($time - t_chg >= 100) q_r = mem[address_pins_in];
    else if ($time - t_chg >= 10) q_r = ~mem[address_pins_in];
  end
  // drive only in a read with good supply
  assign data_pins_oe_out = pwr_ok && !chip_en_n_in && !out_en_n_in && wr_en_n_in;
  assign data_pins_out = q_r;
  // store as the write ends, drop the first on a weak cell
  always @(posedge (chip_en_n_in | wr_en_n_in))
    if (pwr_ok && batt_low_flag) batt_low_flag = 1'b0;
    else if (pwr_ok) mem[address_pins_in] = data_pins_in;
endmodule
`default_nettype wire

// ===== core/bbsp_counter.sv
`timescale 1ns/1ns
`default_nettype none
module bbsp_counter (
  input  wire logic       sys_clk_in,   // system clock
  input  wire logic       rst_in,       // synchronous reset
  input  wire logic       load_in,      // restart the count
  input  wire logic [3:0] count_in,     // cycles to wait
  output logic            expired_out   // count reached zero
);
  logic [3:0] cnt_r;   // remaining cycles
  logic [3:0] cnt_nxt; // next remaining
  logic       exp_r;   // registered expiry
  logic       exp_nxt; // next expiry

  // count down after a load
  always_comb begin
    cnt_nxt = cnt_r;
    exp_nxt = 1'b0;
    if (load_in) begin
      cnt_nxt = count_in;
    end else if (cnt_r > 4'h1) begin
      cnt_nxt = cnt_r - 4'h1;
    end else if (cnt_r == 4'h1) begin
      cnt_nxt = 4'h0;
      exp_nxt = 1'b1;
    end
  end

  // register the counter
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cnt_r <= 4'h0;
      exp_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign expired_out = exp_r;
endmodule
`default_nettype wire

// ===== core/bbsp_defines.svh
`ifndef BBSP_DEFINES_SVH
`define BBSP_DEFINES_SVH
// system clock period in ns
`define BBSP_CLK_NS        20
// address and data widths of the memory port
`define BBSP_ADDR_W        15
`define BBSP_DATA_W        8
// read timing in ns
`define BBSP_T_ADDR_ACC_NS 100
`define BBSP_T_CE_ACC_NS   100
`define BBSP_T_OE_ACC_NS   50
`define BBSP_T_CE_FLT_NS   50
`define BBSP_T_OE_FLT_NS   40
// write timing in ns
`define BBSP_T_WR_PULSE_NS 80
`define BBSP_T_DATA_SU_NS  50
`define BBSP_T_DATA_HLD_NS 5
`define BBSP_T_ADDR_HLD_NS 10
`define BBSP_T_CYCLE_NS    100
// least counts round up, at least one cycle
`define BBSP_CYC_UP(ns) ((((ns) + `BBSP_CLK_NS - 1) / `BBSP_CLK_NS) < 1 ? 1 : \
  (((ns) + `BBSP_CLK_NS - 1) / `BBSP_CLK_NS))
`define BBSP_RD_CYC  `BBSP_CYC_UP(`BBSP_T_ADDR_ACC_NS)
`define BBSP_WR_CYC  `BBSP_CYC_UP(`BBSP_T_WR_PULSE_NS)
`define BBSP_HLD_CYC `BBSP_CYC_UP(`BBSP_T_ADDR_HLD_NS)
`define BBSP_FLT_CYC `BBSP_CYC_UP(`BBSP_T_CE_FLT_NS)
`define BBSP_CYC_CYC `BBSP_CYC_UP(`BBSP_T_CYCLE_NS)
`endif

// ===== core/bbsp_host.sv
// Operation
// - hold address through write, then 10 ns
// - data 50 ns before, 5 ns after end
// - strobe 80 ns, cycles 100 ns apart
// - output enable high during writes
`timescale 1ns/1ns
`default_nettype none
`include "bbsp_defines.svh"
module bbsp_host (
  input  wire logic                      sys_clk_in,        // system clock
  input  wire logic                      rst_in,            // synchronous reset
  input  wire logic                      req_valid_in,      // command request
  input  wire bbsp_pkg::bbsp_cmd_t       req_cmd_in,        // command code
  input  wire logic [`BBSP_ADDR_W-1:0]   req_addr_in,       // byte address
  input  wire logic [`BBSP_DATA_W-1:0]   req_wdata_in,      // write data
  output logic                           req_ready_out,     // idle, takes request
  output logic                           rsp_valid_out,     // answer pulse
  output logic [`BBSP_DATA_W-1:0]        rsp_rdata_out,     // read data
  output logic                           rsp_batt_low_out,  // check found low battery
  output logic [`BBSP_ADDR_W-1:0]        address_pins_out,  // memory address
  output logic                           chip_en_n_out,     // chip enable, low active
  output logic                           out_en_n_out,      // output enable, low active
  output logic                           wr_en_n_out,       // write enable, low active
  input  wire logic [`BBSP_DATA_W-1:0]   data_pins_in,      // data pins level
  output logic [`BBSP_DATA_W-1:0]        data_pins_out,     // data pins drive
  output logic                           data_pins_oe_out   // high while host drives
);
  import bbsp_pkg::*;

  // check routine phases
  localparam logic [1:0] PH_READ1 = 2'h0; // first read
  localparam logic [1:0] PH_INV   = 2'h1; // write complement
  localparam logic [1:0] PH_READ2 = 2'h2; // second read
  localparam logic [1:0] PH_REST  = 2'h3; // restore original

  bbsp_state_t               fsm_r, fsm_nxt;       // sequencer state
  logic [`BBSP_ADDR_W-1:0]   addr_r, addr_nxt;     // address pins
  logic [`BBSP_DATA_W-1:0]   wd_r, wd_nxt;         // write data
  logic [`BBSP_DATA_W-1:0]   orig_r, orig_nxt;     // first read value
  logic [`BBSP_DATA_W-1:0]   rd_r, rd_nxt;         // answer data
  logic                      ce_n_r, ce_n_nxt;     // chip enable
  logic                      oe_n_r, oe_n_nxt;     // output enable
  logic                      we_n_r, we_n_nxt;     // write enable
  logic                      doe_r, doe_nxt;       // data drive enable
  logic                      rv_r, rv_nxt;         // answer pulse
  logic                      low_r, low_nxt;       // battery low result
  logic                      chk_r, chk_nxt;       // check routine active
  logic [1:0]                ph_r, ph_nxt;         // check phase
  logic                      is_wr_r, is_wr_nxt;   // current access writes
  logic                      ld;                   // counter load
  logic [3:0]                ld_cnt;               // counter value
  logic                      tmo;                  // counter expired
  logic [`BBSP_DATA_W-1:0]   din_s1_r, din_s2_r;   // data pin synchroniser

  // wait counter for all timed phases
  bbsp_counter u_cnt (
    .sys_clk_in  (sys_clk_in),
    .rst_in      (rst_in),
    .load_in     (ld),
    .count_in    (ld_cnt),
    .expired_out (tmo)
  );

  // start a read or write access on the pins
  // reads add one cycle of margin so the first sync flop never samples
  // on the very edge where the byte turns valid, and one for the sync
  function automatic logic [3:0] acc_cnt(input logic wr);
    acc_cnt = wr ? 4'(`BBSP_WR_CYC) : 4'(`BBSP_RD_CYC + 2);
  endfunction

  // sequencer next state
  always_comb begin
    fsm_nxt = fsm_r;
    addr_nxt = addr_r;
    wd_nxt = wd_r;
    orig_nxt = orig_r;
    rd_nxt = rd_r;
    ce_n_nxt = ce_n_r;
    oe_n_nxt = oe_n_r;
    we_n_nxt = we_n_r;
    doe_nxt = doe_r;
    rv_nxt = 1'b0;
    low_nxt = low_r;
    chk_nxt = chk_r;
    ph_nxt = ph_r;
    is_wr_nxt = is_wr_r;
    ld = 1'b0;
    ld_cnt = 4'h0;
    case (fsm_r)
      BBSP_IDLE: begin
        if (req_valid_in) begin
          addr_nxt = req_addr_in;
          wd_nxt = req_wdata_in;
          chk_nxt = (req_cmd_in == BBSP_CMD_CHECK);
          ph_nxt = PH_READ1;
          is_wr_nxt = (req_cmd_in == BBSP_CMD_WRITE);
          ce_n_nxt = 1'b0;
          we_n_nxt = ~(req_cmd_in == BBSP_CMD_WRITE);
          // output enable kept high for writes
          oe_n_nxt = (req_cmd_in == BBSP_CMD_WRITE);
          // data driven from the strobe start
          doe_nxt = (req_cmd_in == BBSP_CMD_WRITE);
          ld = 1'b1;
          ld_cnt = acc_cnt(req_cmd_in == BBSP_CMD_WRITE);
          fsm_nxt = (req_cmd_in == BBSP_CMD_WRITE) ? BBSP_WR : BBSP_RD;
        end
      end
      BBSP_RD: begin
        // sample after access time plus sync
        if (tmo) begin
          rd_nxt = din_s2_r;
          ce_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          ld = 1'b1;
          ld_cnt = 4'(`BBSP_FLT_CYC);
          fsm_nxt = BBSP_FLOAT;
        end
      end
      BBSP_WR: begin
        // strobe held at least 80 ns
        if (tmo) begin
          we_n_nxt = 1'b1;
          ce_n_nxt = 1'b1;
          ld = 1'b1;
          ld_cnt = 4'(`BBSP_HLD_CYC);
          fsm_nxt = BBSP_HOLD;
        end
      end
      BBSP_HOLD: begin
        // address and data held past the edge
        if (tmo) begin
          doe_nxt = 1'b0;
          ld = 1'b1;
          ld_cnt = 4'(`BBSP_CYC_CYC);
          fsm_nxt = BBSP_GAP;
        end
      end
      BBSP_FLOAT: begin
        if (tmo) begin
          ld = 1'b1;
          ld_cnt = 4'(`BBSP_CYC_CYC);
          fsm_nxt = BBSP_GAP;
        end
      end
      BBSP_GAP: begin
        // cycles spaced at least 100 ns
        if (tmo) begin
          fsm_nxt = BBSP_DONE;
        end
      end
      BBSP_DONE: begin
        fsm_nxt = BBSP_IDLE;
        if (!chk_r) begin
          rv_nxt = 1'b1;
        end else begin
          case (ph_r)
            PH_READ1: begin
              orig_nxt = rd_r;
              wd_nxt = ~rd_r;
              ph_nxt = PH_INV;
              is_wr_nxt = 1'b1;
            end
            PH_INV: begin
              ph_nxt = PH_READ2;
              is_wr_nxt = 1'b0;
            end
            PH_READ2: begin
              low_nxt = (rd_r == orig_r);
              wd_nxt = orig_r;
              ph_nxt = PH_REST;
              is_wr_nxt = 1'b1;
            end
            default: begin
              chk_nxt = 1'b0;
              rd_nxt = orig_r;
              rv_nxt = 1'b1;
            end
          endcase
          if (ph_r != PH_REST) begin
            ce_n_nxt = 1'b0;
            we_n_nxt = ~is_wr_nxt;
            oe_n_nxt = is_wr_nxt;
            doe_nxt = is_wr_nxt;
            ld = 1'b1;
            ld_cnt = acc_cnt(is_wr_nxt);
            fsm_nxt = is_wr_nxt ? BBSP_WR : BBSP_RD;
          end
        end
      end
      default: begin
        fsm_nxt = BBSP_IDLE;
      end
    endcase
  end

  // register sequencer and pin drivers
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      fsm_r <= BBSP_IDLE;
      addr_r <= '0;
      wd_r <= '0;
      orig_r <= '0;
      rd_r <= '0;
      ce_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      we_n_r <= 1'b1;
      doe_r <= 1'b0;
      rv_r <= 1'b0;
      low_r <= 1'b0;
      chk_r <= 1'b0;
      ph_r <= PH_READ1;
      is_wr_r <= 1'b0;
    end else begin
      fsm_r <= fsm_nxt;
      addr_r <= addr_nxt;
      wd_r <= wd_nxt;
      orig_r <= orig_nxt;
      rd_r <= rd_nxt;
      ce_n_r <= ce_n_nxt;
      oe_n_r <= oe_n_nxt;
      we_n_r <= we_n_nxt;
      doe_r <= doe_nxt;
      rv_r <= rv_nxt;
      low_r <= low_nxt;
      chk_r <= chk_nxt;
      ph_r <= ph_nxt;
      is_wr_r <= is_wr_nxt;
    end
  end

  // two-flop synchroniser on data pins
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      din_s1_r <= '0;
      din_s2_r <= '0;
    end else begin
      din_s1_r <= data_pins_in;
      din_s2_r <= din_s1_r;
    end
  end

  // ready is the registered idle state
  logic rdy_r; // idle flag
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rdy_r <= 1'b1;
    end else begin
      rdy_r <= (fsm_nxt == BBSP_IDLE);
    end
  end

  assign req_ready_out    = rdy_r;
  assign rsp_valid_out    = rv_r;
  assign rsp_rdata_out    = rd_r;
  assign rsp_batt_low_out = low_r;
  assign address_pins_out = addr_r;
  assign chip_en_n_out    = ce_n_r;
  assign out_en_n_out     = oe_n_r;
  assign wr_en_n_out      = we_n_r;
  assign data_pins_out    = wd_r;
  assign data_pins_oe_out = doe_r;
endmodule
`default_nettype wire

// ===== core/bbsp_pkg.sv
`default_nettype none
package bbsp_pkg;
  // host command codes
  typedef enum logic [1:0] {
    BBSP_CMD_READ  = 2'h0,
    BBSP_CMD_WRITE = 2'h1,
    BBSP_CMD_CHECK = 2'h2
  } bbsp_cmd_t;
  // sequencer states, one-hot
  typedef enum logic [6:0] {
    BBSP_IDLE  = 7'h01,
    BBSP_RD    = 7'h02,
    BBSP_WR    = 7'h04,
    BBSP_HOLD  = 7'h08,
    BBSP_FLOAT = 7'h10,
    BBSP_GAP   = 7'h20,
    BBSP_DONE  = 7'h40
  } bbsp_state_t;
endpackage
`default_nettype wire
